/* rtl/ovr_regs_pkg.sv */
// Constants for the over-range, init status and power-mode register slice.
// Assumes the serial port uses a 24-bit frame: R/W, 15 address bits, 8 data bits.
package ovr_regs_pkg;

   // Register byte addresses on the serial port
   localparam logic [14:0] ADDR_OVR_THRESH = 15'h0211;
   localparam logic [14:0] ADDR_OVERRANGE_OUTPUT_CONFIG    = 15'h0213;
   localparam logic [14:0] ADDR_INIT_STAT  = 15'h0270;
   localparam logic [14:0] ADDR_PM_B       = 15'h029a;
   localparam logic [14:0] ADDR_PM_C       = 15'h029b;
   localparam logic [14:0] ADDR_PM_D       = 15'h029c;

   // Reset values
   localparam logic [7:0] RST_OVR_THRESH = 8'hf2;
   localparam logic [7:0] RST_OVERRANGE_OUTPUT_CONFIG    = 8'h07;
   localparam logic [7:0] RST_READ_NONE  = 8'h00;

   // Power-mode codes
   localparam logic [7:0] PM_B_LOW = 8'h06;
   localparam logic [7:0] PM_B_HP  = 8'h0f;
   localparam logic [7:0] PM_C_LOW = 8'h00;
   localparam logic [7:0] PM_C_HP  = 8'h04;
   localparam logic [7:0] PM_D_LOW = 8'h14;
   localparam logic [7:0] PM_D_HP  = 8'h1b;

   // Field positions
   localparam int OVERRANGE_OUTPUT_ENABLE_BIT    = 3;
   localparam int OVR_EXP_MSB   = 2;
   localparam int OVR_EXP_LSB   = 0;
   localparam int INIT_DONE_BIT = 0;

   // Serial frame layout, counted in clock-in bits
   localparam logic [4:0] HDR_LAST_BIT  = 5'h0f;
   localparam logic [4:0] FRAME_LAST_BIT = 5'h17;
   localparam logic [4:0] DATA_FIRST_BIT = 5'h10;

   // Pulse stretch: base length times two to the exponent
   localparam logic [9:0] STRETCH_BASE = 10'h004;
   localparam int         THR_SHIFT    = 3;

   function automatic logic [9:0] min_len(input logic [2:0] exp);
      min_len = STRETCH_BASE << exp;
   endfunction

endpackage

/* rtl/overrange_output_config_if.sv */
// Over-range settings shared from the register slice to the channel detectors.
// Assumes one driver (the register slice) and any number of readers.
`timescale 1ns/1ps
interface overrange_output_config_if;
   logic       en;
   logic [2:0] exp;
   logic [7:0] thr;
   modport src  (output en, output exp, output thr);
   modport chan (input en, input exp, input thr);
endinterface

/* rtl/ovr_channel.sv */
// One channel's over-range detector and pulse stretcher.
// Assumes samples are signed and arrive on ref_clk, the sampling clock.
`timescale 1ns/1ps
module ovr_channel
   import ovr_regs_pkg::*;
#(
   parameter int SAMPLE_W = 12
) (
   input  wire logic                ref_clk,
   input  wire logic                rst,
   overrange_output_config_if.chan                  cfg,
   input  wire logic [SAMPLE_W-1:0] sample,
   output logic                     out_q
);

   logic [SAMPLE_W-1:0] mag;
   logic [SAMPLE_W-1:0] level;
   logic                hit;
   logic [9:0]          cnt_q;
   logic [9:0]          hi_len_q;

   // threshold over 256 of full scale
   always_comb begin
      mag   = sample[SAMPLE_W-1] ? SAMPLE_W'(-sample) : sample;
      level = SAMPLE_W'({cfg.thr, THR_SHIFT'(0)}) << (SAMPLE_W - 1 - 8 - THR_SHIFT);
      hit   = mag >= level;
   end

   // load or reload the hold count
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (hit) begin
         cnt_q <= min_len(cfg.exp) - 10'h001;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 10'h001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         out_q <= 1'b0;
      end else begin
         out_q <= cfg.en & (hit | (cnt_q != '0));
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hi_len_q <= '0;
      end else begin
         hi_len_q <= out_q ? hi_len_q + 10'h001 : '0;
      end
   end

   property p_forced_low;
      @(posedge ref_clk) disable iff (rst)
      !cfg.en |=> !out_q;
   endproperty
   a_forced_low: assert property (p_forced_low)
      else $error("over-range pin high while disabled");

   property p_min_width;
      @(posedge ref_clk) disable iff (rst)
      $fell(out_q) && $past(cfg.en) && $stable(cfg.exp) |-> hi_len_q >= min_len(cfg.exp);
   endproperty
   a_min_width: assert property (p_min_width)
      else $error("over-range pulse shorter than minimum");

   property p_detect;
      @(posedge ref_clk) disable iff (rst)
      cfg.en && hit |=> out_q;
   endproperty
   a_detect: assert property (p_detect)
      else $error("over-range level missed");

   property p_restart;
      @(posedge ref_clk) disable iff (rst)
      out_q && hit |=> cnt_q == min_len($past(cfg.exp)) - 10'h001;
   endproperty
   a_restart: assert property (p_restart)
      else $error("hold count not restarted");

endmodule

/* rtl/ovr_init_power_regs.sv */
// Serial-port register slice: over-range settings, init status, power modes.
// Assumes serial pins are asynchronous to ref_clk and sclk runs below ref_clk/8.
// How it works
// - Over-range pins follow detection only while the enable bit is set, else low.
// - Each over-range pulse lasts at least four times two-to-the-exponent cycles.
// - A channel flags when sample magnitude reaches threshold over 256 of full scale.
// - Init status bit reads 0 until internal start-up finishes, then 1.
// - Second power-mode register: 0x06 low power, 0x0f high performance, reset 0x0f.
// - Third power-mode register: 0x00 low power, 0x04 high performance, reset 0x04.
// - Fourth power-mode register: 0x14 low power, 0x1b high performance, reset 0x1b.
`timescale 1ns/1ps
module ovr_init_power_regs
   import ovr_regs_pkg::*;
#(
   parameter int NUM_CH      = 4,
   parameter int SAMPLE_W    = 12,
   parameter int INIT_CYCLES = 256
) (
   input  wire logic                           ref_clk,
   input  wire logic                           rst,
   input  wire logic                           spi_sclk,
   input  wire logic                           spi_cs_n,
   input  wire logic                           spi_sdi,
   output logic                                spi_sdo,
   output logic                                spi_sdo_oe,
   input  wire logic [NUM_CH-1:0][SAMPLE_W-1:0] sample,
   output logic                                overrange_out_a,
   output logic                                overrange_out_b,
   output logic                                overrange_out_c,
   output logic                                overrange_out_d,
   output logic [7:0]                          power_mode_code_b,
   output logic [7:0]                          power_mode_code_c,
   output logic [7:0]                          power_mode_code_d
);

   logic        cs_n_s1, cs_n_s2;
   logic        sclk_s1, sclk_s2, sclk_s3;
   logic        sdi_s1, sdi_s2;
   logic        active;
   logic        rise;
   logic        fall;
   logic [4:0]  bit_cnt_q;
   logic [22:0] shift_q;
   logic        hdr_rd_q;
   logic [14:0] hdr_addr_q;
   logic [7:0]  rd_sh_q;
   logic [7:0]  rd_data;
   logic [14:0] hdr_addr;
   logic        wr_stb;
   logic [7:0]  wr_data;
   logic [7:0]  ovr_thr_q;
   logic [7:0]  overrange_output_config_q;
   logic [7:0]  pm_b_q;
   logic [7:0]  pm_c_q;
   logic [7:0]  pm_d_q;
   logic        init_done_q;
   logic [$clog2(INIT_CYCLES+1)-1:0] init_cnt_q;
   logic [NUM_CH-1:0] ovr_q;

   // Two-stage synchronisers; edge detect reads only the second stage onward
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cs_n_s1 <= 1'b1;
         cs_n_s2 <= 1'b1;
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_s3 <= 1'b0;
         sdi_s1  <= 1'b0;
         sdi_s2  <= 1'b0;
      end else begin
         cs_n_s1 <= spi_cs_n;
         cs_n_s2 <= cs_n_s1;
         sclk_s1 <= spi_sclk;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
         sdi_s1  <= spi_sdi;
         sdi_s2  <= sdi_s1;
      end
   end

   assign active   = ~cs_n_s2;
   assign rise     = active & sclk_s2 & ~sclk_s3;
   assign fall     = active & ~sclk_s2 & sclk_s3;
   assign hdr_addr = {shift_q[13:0], sdi_s2};
   assign wr_data  = {shift_q[6:0], sdi_s2};
   assign wr_stb   = rise & (bit_cnt_q == FRAME_LAST_BIT) & ~hdr_rd_q;

   // Frame shifter; deselect abandons a partial frame
   always_ff @(posedge ref_clk) begin
      if (rst || !active) begin
         bit_cnt_q <= '0;
         shift_q   <= '0;
      end else if (rise) begin
         shift_q   <= {shift_q[21:0], sdi_s2};
         bit_cnt_q <= (bit_cnt_q == FRAME_LAST_BIT) ? '0 : bit_cnt_q + 5'h01;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hdr_rd_q   <= 1'b0;
         hdr_addr_q <= '0;
      end else if (rise && bit_cnt_q == HDR_LAST_BIT) begin
         hdr_rd_q   <= shift_q[14];
         hdr_addr_q <= hdr_addr;
      end
   end

   // Unmapped addresses read as zero
   always_comb begin
      rd_data = RST_READ_NONE;
      case (hdr_addr)
         ADDR_OVR_THRESH: rd_data = ovr_thr_q;
         ADDR_OVERRANGE_OUTPUT_CONFIG:    rd_data = overrange_output_config_q;
         ADDR_INIT_STAT:  rd_data = {7'h00, init_done_q};
         ADDR_PM_B:       rd_data = pm_b_q;
         ADDR_PM_C:       rd_data = pm_c_q;
         ADDR_PM_D:       rd_data = pm_d_q;
         default:         rd_data = RST_READ_NONE;
      endcase
   end

   // Read data shifts out on falling sclk, MSB first
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rd_sh_q <= '0;
         spi_sdo <= 1'b0;
      end else if (rise && bit_cnt_q == HDR_LAST_BIT) begin
         rd_sh_q <= rd_data;
      end else if (fall && bit_cnt_q >= DATA_FIRST_BIT) begin
         spi_sdo <= rd_sh_q[7];
         rd_sh_q <= {rd_sh_q[6:0], 1'b0};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         spi_sdo_oe <= 1'b0;
      end else begin
         spi_sdo_oe <= active;
      end
   end

   // Reserved upper bits are stored as written, host keeps them zero
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ovr_thr_q <= RST_OVR_THRESH;
         overrange_output_config_q <= RST_OVERRANGE_OUTPUT_CONFIG;
      end else if (wr_stb && hdr_addr_q == ADDR_OVR_THRESH) begin
         ovr_thr_q <= wr_data;
      end else if (wr_stb && hdr_addr_q == ADDR_OVERRANGE_OUTPUT_CONFIG) begin
         overrange_output_config_q <= wr_data;
      end
   end

   // power-mode codes, high performance after reset
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pm_b_q <= PM_B_HP;
         pm_c_q <= PM_C_HP;
         pm_d_q <= PM_D_HP;
      end else if (wr_stb) begin
         if (hdr_addr_q == ADDR_PM_B) pm_b_q <= wr_data;
         if (hdr_addr_q == ADDR_PM_C) pm_c_q <= wr_data;
         if (hdr_addr_q == ADDR_PM_D) pm_d_q <= wr_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         power_mode_code_b <= PM_B_HP;
         power_mode_code_c <= PM_C_HP;
         power_mode_code_d <= PM_D_HP;
      end else begin
         power_mode_code_b <= pm_b_q;
         power_mode_code_c <= pm_c_q;
         power_mode_code_d <= pm_d_q;
      end
   end

   // init finishes a fixed time after reset
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         init_cnt_q  <= '0;
         init_done_q <= 1'b0;
      end else if (!init_done_q) begin
         init_cnt_q  <= init_cnt_q + 1'b1;
         init_done_q <= (init_cnt_q == ($bits(init_cnt_q))'(INIT_CYCLES - 1));
      end
   end

   overrange_output_config_if cfg ();
   assign cfg.en  = overrange_output_config_q[OVERRANGE_OUTPUT_ENABLE_BIT];
   assign cfg.exp = overrange_output_config_q[OVR_EXP_MSB:OVR_EXP_LSB];
   assign cfg.thr = ovr_thr_q;

   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      ovr_channel #(
         .SAMPLE_W (SAMPLE_W)
      ) u_ch (
         .ref_clk (ref_clk),
         .rst     (rst),
         .cfg     (cfg.chan),
         .sample  (sample[i]),
         .out_q   (ovr_q[i])
      );
   end

   // Pins come straight from the channel flops
   assign overrange_out_a = ovr_q[0];
   assign overrange_out_b = ovr_q[1];
   assign overrange_out_c = ovr_q[2];
   assign overrange_out_d = ovr_q[3];

   property p_init_time;
      @(posedge ref_clk) disable iff (rst)
      $rose(init_done_q) |-> $past(init_cnt_q) == ($bits(init_cnt_q))'(INIT_CYCLES - 1);
   endproperty
   a_init_time: assert property (p_init_time)
      else $error("init done at wrong time");

   property p_pm_b;
      @(posedge ref_clk) disable iff (rst)
      wr_stb && hdr_addr_q == ADDR_PM_B |=> ##1 power_mode_code_b == $past(wr_data, 2);
   endproperty
   a_pm_b: assert property (p_pm_b)
      else $error("power mode b write not applied");

   property p_pm_c;
      @(posedge ref_clk)
      rst ##1 !rst |-> power_mode_code_c == PM_C_HP;
   endproperty
   a_pm_c: assert property (p_pm_c)
      else $error("power mode c reset value wrong");

   property p_pm_d;
      @(posedge ref_clk) disable iff (rst)
      !(wr_stb && hdr_addr_q == ADDR_PM_D) |=> pm_d_q == $past(pm_d_q);
   endproperty
   a_pm_d: assert property (p_pm_d)
      else $error("power mode d changed without write");

endmodule

/* test/spi_host_model.sv */
// Host model for the serial register port: mode-0 frames, 24 bits MSB first.
// Assumes ref_clk is the device clock; each sclk phase lasts 6 ref_clk cycles.
`timescale 1ns/1ps
module spi_host_model (
   input  wire logic ref_clk,
   input  wire logic spi_sdo,
   output logic      spi_sclk,
   output logic      spi_cs_n,
   output logic      spi_sdi
);
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_sdi  = 1'b0;
   end

   // Read bits are taken just before each rise, after a full low phase
   task automatic xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wdata,
                       output logic [7:0] rdata);
      logic [23:0] frame;
      frame = {rd, addr, wdata};
      rdata = 8'h00;
      @(posedge ref_clk) spi_cs_n <= 1'b0;
      for (int i = 23; i >= 0; i--) begin
         spi_sdi <= frame[i];
         repeat (6) @(posedge ref_clk);
         if (i < 8) rdata[i] = spi_sdo;
         spi_sclk <= 1'b1;
         repeat (6) @(posedge ref_clk);
         spi_sclk <= 1'b0;
      end
      repeat (6) @(posedge ref_clk);
      spi_cs_n <= 1'b1;
      // Released data line must not keep looking valid
      spi_sdi  <= ~frame[0];
      repeat (6) @(posedge ref_clk);
   endtask
endmodule

/* test/overrange_init_power_regs_tb.sv */
// Self-checking bench for the register slice and over-range pins.
// Assumes the host model above; init count raised to 1000 cycles.
`timescale 1ns/1ps
module overrange_init_power_regs_tb;
   import ovr_regs_pkg::*;
   typedef struct packed {logic rd; logic [14:0] addr; logic [7:0] data;} row_t;
   logic            ref_clk, rst, spi_sclk, spi_cs_n, spi_sdi, spi_sdo, sdo_oe;
   logic [3:0][11:0] sample;
   logic [3:0]      ovr_pins;
   logic [7:0]      pm_b, pm_c, pm_d, rdata;
   int              fail_count = 0;
   int              cmp_count = 0;
   row_t            rows [14] = '{
      '{1'b1, ADDR_PM_B, PM_B_HP}, '{1'b1, ADDR_PM_C, PM_C_HP}, '{1'b1, ADDR_PM_D, PM_D_HP},
      '{1'b1, ADDR_OVERRANGE_OUTPUT_CONFIG, RST_OVERRANGE_OUTPUT_CONFIG}, '{1'b1, ADDR_OVR_THRESH, RST_OVR_THRESH},
      '{1'b0, ADDR_PM_B, PM_B_LOW}, '{1'b0, ADDR_PM_C, PM_C_LOW}, '{1'b0, ADDR_PM_D, PM_D_LOW},
      '{1'b1, ADDR_PM_B, PM_B_LOW}, '{1'b1, ADDR_PM_C, PM_C_LOW}, '{1'b1, ADDR_PM_D, PM_D_LOW},
      '{1'b0, ADDR_INIT_STAT, 8'h00}, '{1'b1, ADDR_INIT_STAT, 8'h01},
      '{1'b1, 15'h0200, RST_READ_NONE}};
   logic [11:0]     hit_vals [4] = '{12'h790, 12'h870, 12'h800, 12'h7ff};

   ovr_init_power_regs #(.INIT_CYCLES(1000)) i_ovr_init_power_regs (
      .ref_clk(ref_clk), .rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(sdo_oe), .sample(sample),
      .overrange_out_a(ovr_pins[0]), .overrange_out_b(ovr_pins[1]),
      .overrange_out_c(ovr_pins[2]), .overrange_out_d(ovr_pins[3]),
      .power_mode_code_b(pm_b), .power_mode_code_c(pm_c), .power_mode_code_d(pm_d));

   spi_host_model i_spi_host_model (
      .ref_clk(ref_clk), .spi_sdo(spi_sdo), .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      i_spi_host_model.xfer(1'b0, a, d, rdata);
   endtask

   // One or two hits on a channel, then count how long its pin stays high
   task automatic hit(input int ch, input logic [11:0] val, input int gap,
                      input logic [7:0] len);
      logic [7:0] seen;
      seen = 8'h00;
      sample[ch] <= val;
      // Count from the cycle after the first hit, gap cycles included
      for (int t = 0; t <= 80; t++) begin
         @(posedge ref_clk);
         if (t > 0) seen = seen + 8'(ovr_pins[ch]);
         if (t < 80) sample[ch] <= (t + 1 == gap) ? val : 12'h000;
      end
      check(seen, len);
   endtask

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   initial begin
      repeat (40000) @(posedge ref_clk);
      fail_count++;
      tally_and_finish();
   end

   initial begin
      rst    = 1'b1;
      sample = '0;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      check(pm_b, PM_B_HP);
      check(pm_c, PM_C_HP);
      check(pm_d, PM_D_HP);
      check(8'(ovr_pins), 8'h00);
      check(8'(sdo_oe), 8'h00);
      // Early read on purpose: status must still be clear
      fork
         i_spi_host_model.xfer(1'b1, ADDR_INIT_STAT, 8'h00, rdata);
         begin
            repeat (20) @(posedge ref_clk);
            check(8'(sdo_oe), 8'h01);
         end
      join
      check(rdata, 8'h00);
      for (int n = 0; n < 8 && rdata !== 8'h01; n++)
         i_spi_host_model.xfer(1'b1, ADDR_INIT_STAT, 8'h00, rdata);
      check(rdata, 8'h01);
      // reset values read back, low-power codes written and read, status write ignored, unmapped read
      foreach (rows[k]) begin
         i_spi_host_model.xfer(rows[k].rd, rows[k].addr, rows[k].data, rdata);
         if (rows[k].rd) check(rdata, rows[k].data);
      end
      repeat (2) @(posedge ref_clk);
      check(pm_b, PM_B_LOW);
      check(pm_c, PM_C_LOW);
      check(pm_d, PM_D_LOW);
      wr(ADDR_PM_B, PM_B_HP);
      wr(ADDR_PM_C, PM_C_HP);
      wr(ADDR_PM_D, PM_D_HP);
      repeat (2) @(posedge ref_clk);
      check(pm_b, PM_B_HP);
      check(pm_c, PM_C_HP);
      check(pm_d, PM_D_HP);
      hit(0, 12'h790, 0, 8'd0);
      wr(ADDR_OVERRANGE_OUTPUT_CONFIG, 8'h08);
      for (int c = 0; c < 4; c++)
         hit(c, hit_vals[c], 0, 8'd4);
      hit(0, 12'h78f, 0, 8'd0);
      hit(1, 12'h871, 0, 8'd0);
      hit(2, 12'h790, 3, 8'd7);
      wr(ADDR_OVERRANGE_OUTPUT_CONFIG, 8'h0a);
      hit(3, 12'h790, 0, 8'd16);
      wr(ADDR_OVR_THRESH, 8'h10);
      hit(0, 12'h080, 0, 8'd16);
      hit(0, 12'h07f, 0, 8'd0);
      wr(ADDR_OVERRANGE_OUTPUT_CONFIG, 8'h02);
      hit(0, 12'h7ff, 0, 8'd0);
      tally_and_finish();
   end
endmodule
